// ===== core/pwmdou_pkg.sv
// Purpose: shared constants and types for the pwm duty/override generator
// Assumes: one generator, ports instead of registers
// Notes:   field positions and the duty, period and prescale reset values live here
package pwmdou_pkg;
  localparam int DUTY_W        = 16;
  localparam int PRESCALE_W    = 3;
  // output mode field encodings
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_REDUNDANT = 2'h2;
  // override patterns, high bit drives the high side
  localparam logic [1:0] OVR_ZERO_DUTY  = 2'h1;
  localparam logic [1:0] OVR_FULL_DUTY  = 2'h2;
  localparam logic [DUTY_W-1:0] DUTY_RESET   = 16'h0000;
  localparam logic [DUTY_W-1:0] PERIOD_RESET = 16'h0010;
  localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 3'h0;

  typedef struct packed {
    logic [1:0] outputMode;
    logic       overrideEnable;
    logic       overrideSyncSelect;
    logic [1:0] overridePatternBits;
  } pwmdou_out_ctrl_s;

  typedef struct packed {
    logic immediateUpdate;
    logic masterDutySelect;
  } pwmdou_gen_ctrl_s;

  typedef struct packed {
    logic highSideOutput;
    logic lowSideOutput;
  } pwmdou_pair_s;
endpackage

// ===== core/pwmdou_prescaler.sv
// Purpose: pwm clock tick from the system clock
// Assumes: field value n gives one tick every 2**n clocks
// Notes:   tick is a one-cycle pulse, no second clock domain
`timescale 1ns/1ps
module pwmdou_prescaler #(
  parameter int PRESCALE_W = 3
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // control
  input  wire logic                  run,
  input  wire logic [PRESCALE_W-1:0] prescale,
  // tick
  output logic                       tick
);
  localparam int CNT_W = 1 << PRESCALE_W;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] limit;

  always_comb begin
    limit = CNT_W'((64'h1 << prescale) - 64'h1);
    tick  = run && (count_reg >= limit);
    if (!run || tick) begin
      count_next = '0;
    end else begin
      count_next = count_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// ===== core/pwmdou_generator.sv
// Purpose: duty update and output override of one pwm generator
// Assumes: control bits arrive as ports on ref_clk, same domain
// Notes:   edge-aligned counter, period from port
`timescale 1ns/1ps
module pwmdou_generator #(
  parameter int DUTY_W     = pwmdou_pkg::DUTY_W,
  parameter int PRESCALE_W = pwmdou_pkg::PRESCALE_W
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  // module time control
  input  wire logic                     moduleEnable,
  input  wire logic [PRESCALE_W-1:0]    pwmClockPrescale,
  input  wire logic [DUTY_W-1:0]        periodValue,
  // generator control
  input  wire pwmdou_pkg::pwmdou_gen_ctrl_s genCtrl,
  input  wire pwmdou_pkg::pwmdou_out_ctrl_s outCtrl,
  input  wire logic [DUTY_W-1:0]        generatorDutyValue,
  input  wire logic [DUTY_W-1:0]        masterDutyValue,
  // status
  output logic [DUTY_W-1:0]             activeDuty,
  output logic                          periodBoundary,
  // output pair
  output pwmdou_pkg::pwmdou_pair_s      outputPair
);
  //////////////////////////////////////////////////////////////////////////////
  logic                     pwmTick;
  logic [DUTY_W-1:0]        selectedDuty;
  logic                     wrapNow;

  logic                     modeRedundant;
  logic                     modePushPull;
  logic                     waveHigh;

  logic [DUTY_W-1:0]        counter_reg;
  logic [DUTY_W-1:0]        counter_next;
  logic [DUTY_W-1:0]        duty_reg;
  logic [DUTY_W-1:0]        duty_next;
  logic                     phase_reg;
  logic                     phase_next;

  logic [1:0]               ovrLatched_reg;
  logic [1:0]               ovrLatched_next;
  logic                     ovrOn_reg;
  logic                     ovrOn_next;

  pwmdou_pkg::pwmdou_pair_s pair_reg;
  pwmdou_pkg::pwmdou_pair_s pair_next;

  pwmdou_prescaler #(
    .PRESCALE_W (PRESCALE_W)
  ) u_prescaler (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .run      (moduleEnable),
    .prescale (pwmClockPrescale),
    .tick     (pwmTick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // time base: counter runs 0..periodValue, one step per pwm tick
  always_comb begin
    // >= so a period shortened below the count still wraps on the next pwm tick
    wrapNow      = pwmTick && (counter_reg >= periodValue);
    counter_next = counter_reg;
    if (!moduleEnable) begin
      counter_next = '0;
    end else if (wrapNow) begin
      counter_next = '0;
    end else if (pwmTick) begin
      counter_next = counter_reg + DUTY_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counter_reg <= pwmdou_pkg::DUTY_RESET;
    end else begin
      counter_reg <= counter_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // push-pull phase, flips once per period
  always_comb begin
    phase_next = phase_reg;
    if (!moduleEnable) begin
      // restart at enable so the first period goes to the high side
      phase_next = 1'b0;
    end else if (wrapNow) begin
      phase_next = ~phase_reg;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // duty source and duty latch
  always_comb begin
    selectedDuty = genCtrl.masterDutySelect ? masterDutyValue
                                            : generatorDutyValue;
    duty_next    = duty_reg;
    if (!moduleEnable) begin
      // stopped module drives nothing to tear, so track at once
      duty_next = selectedDuty;
    end else if (genCtrl.immediateUpdate) begin
      duty_next = selectedDuty;
    end else if (wrapNow) begin
      duty_next = selectedDuty;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      duty_reg <= pwmdou_pkg::DUTY_RESET;
    end else begin
      duty_reg <= duty_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // override latch: cpu-clock select follows at once, sync select waits for period for both set and clear
  always_comb begin
    ovrLatched_next = ovrLatched_reg;
    ovrOn_next      = ovrOn_reg;
    // a stopped module has no period edge to wait for
    if (!outCtrl.overrideSyncSelect || !moduleEnable || wrapNow) begin
      ovrLatched_next = outCtrl.overridePatternBits;
      ovrOn_next      = outCtrl.overrideEnable;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovrLatched_reg <= 2'h0;
      ovrOn_reg      <= 1'b0;
    end else begin
      ovrLatched_reg <= ovrLatched_next;
      ovrOn_reg      <= ovrOn_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output mode decode
  always_comb begin
    modeRedundant = 1'b0;
    modePushPull  = 1'b0;
    unique case (outCtrl.outputMode)
      pwmdou_pkg::MODE_REDUNDANT: begin
        modeRedundant = 1'b1;
      end
      pwmdou_pkg::MODE_PUSH_PULL: begin
        modePushPull = 1'b1;
      end
      default: begin
        // remaining codes run complementary
        modeRedundant = 1'b0;
        modePushPull  = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // output stage, registered so no comparator glitch reaches the pins
  always_comb begin
    // compare against the latched duty only, so zero duty is never high
    waveHigh                 = moduleEnable && (duty_reg != '0) && (counter_reg < duty_reg);
    pair_next.highSideOutput = 1'b0;
    pair_next.lowSideOutput  = 1'b0;
    if (ovrOn_next) begin
      // next-state override, so a cpu-clock change lands on the next edge
      pair_next.highSideOutput = ovrLatched_next[1];
      pair_next.lowSideOutput  = ovrLatched_next[0];
    end else if (modeRedundant) begin
      pair_next.highSideOutput = waveHigh;
      pair_next.lowSideOutput  = waveHigh;
    end else if (modePushPull) begin
      pair_next.highSideOutput = waveHigh && !phase_reg;
      pair_next.lowSideOutput  = waveHigh && phase_reg;
    end else begin
      // complementary, no dead time here
      pair_next.highSideOutput = waveHigh;
      pair_next.lowSideOutput  = moduleEnable && !waveHigh;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pair_reg <= '0;
    end else begin
      pair_reg <= pair_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status and pins
  // immediate-update must be set before moduleEnable by software
  assign outputPair     = pair_reg;
  assign activeDuty     = duty_reg;
  assign periodBoundary = wrapNow;
endmodule

// ===== testbench/pwmdou_stage.sv
// Purpose: power stage seen as a load
// Assumes: one cycle per sample
// Notes:   counts on-cycles per side
`timescale 1ns/1ps
module pwmdou_stage (
  // clock, clear
  input wire logic              ref_clk,
  input wire logic              clr,
  // pair in, counts out
  input wire pwmdou_pkg::pwmdou_pair_s pin,
  output int                    hiCnt,
  output int                    loCnt
);
  always @(posedge ref_clk) begin
    hiCnt <= clr ? 0 : hiCnt + int'(pin.highSideOutput);
    loCnt <= clr ? 0 : loCnt + int'(pin.lowSideOutput);
  end
endmodule

// ===== testbench/pwmdou_sva.sv
// Purpose: port checks of the generator
// Assumes: one clock domain
// Notes:   bound from the bench
`timescale 1ns/1ps
module pwmdou_sva (
  // clock, reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // inputs
  input wire logic        moduleEnable,
  input wire logic [2:0]  pwmClockPrescale,
  input wire logic [15:0] periodValue,
  input wire pwmdou_pkg::pwmdou_gen_ctrl_s genCtrl,
  input wire pwmdou_pkg::pwmdou_out_ctrl_s outCtrl,
  input wire logic [15:0] generatorDutyValue,
  input wire logic [15:0] masterDutyValue,
  // outputs
  input wire logic [15:0] activeDuty,
  input wire logic        periodBoundary,
  input wire pwmdou_pkg::pwmdou_pair_s outputPair
);
  logic [15:0] sel;
  logic [1:0]  pair;
  logic        ovr;
  logic        live;
  assign sel = genCtrl.masterDutySelect ? masterDutyValue : generatorDutyValue;
  assign pair = outputPair;
  assign ovr = outCtrl.overrideEnable;
  // first edge after reset: $past still sees reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst)
      live <= 1'b0;
    else
      live <= 1'b1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence en8; moduleEnable[*8]; endsequence
  sequence bnd1; periodBoundary && pwmClockPrescale == 3'h1 && periodValue == 16'h0003; endsequence
  idle_sel_a: assert property (live && !$past(moduleEnable) |-> activeDuty == $past(sel))
    else $error("idle duty wrong");
  imm_load_a: assert property (
    live && $past(moduleEnable && genCtrl.immediateUpdate) |-> activeDuty == $past(sel))
    else $error("duty not immediate");
  duty_hold_a: assert property (
    live && $past(moduleEnable && !genCtrl.immediateUpdate && !periodBoundary)
    |-> $stable(activeDuty))
    else $error("duty changed early");
  edge_load_a: assert property (
    live && $past(moduleEnable && !genCtrl.immediateUpdate && periodBoundary)
    |-> activeDuty == $past(sel))
    else $error("duty not loaded");
  zero_low_a: assert property (
    live && activeDuty == 16'h0000 && $past(activeDuty) == 16'h0000
    && $past(moduleEnable && !ovr && ^outCtrl.outputMode) |-> pair == 2'h0)
    else $error("zero duty glitch");
  ovr_force_a: assert property (
    live && $past(ovr && !outCtrl.overrideSyncSelect)
    |-> pair == $past(outCtrl.overridePatternBits))
    else $error("override not applied");
  redund_pair_a: assert property (live && $past(outCtrl.outputMode == 2'h2 && !ovr)
    |-> pair[1] == pair[0])
    else $error("redundant pair differs");
  period_len_a: assert property (bnd1 ##1 en8 |-> periodBoundary)
    else $error("period length wrong");
endmodule

// ===== testbench/pwmdou_test.sv
// Purpose: scenario bench of the generator
// Assumes: period 3, small duties
// Notes:   on-time read from the stage model
`timescale 1ns/1ps
module pwm_duty_override_update_test;
  logic        ref_clk = 0, rst = 1, en = 0, clr = 0, pb;
  logic [2:0]  ps = 3'h0;
  logic [15:0] gd = 16'h0002, md = 16'h0001, ad;
  pwmdou_pkg::pwmdou_gen_ctrl_s gc = 2'h2;
  pwmdou_pkg::pwmdou_out_ctrl_s oc = 6'h20;
  pwmdou_pkg::pwmdou_pair_s     op;
  int          hiCnt, loCnt, numErrors = 0, checks = 0, n;
  always #50 ref_clk = ~ref_clk;
  pwmdou_generator dut (.ref_clk(ref_clk), .rst(rst), .moduleEnable(en),
    .pwmClockPrescale(ps), .periodValue(16'h0003), .genCtrl(gc), .outCtrl(oc),
    .generatorDutyValue(gd), .masterDutyValue(md), .activeDuty(ad),
    .periodBoundary(pb), .outputPair(op));
  pwmdou_stage stage (.ref_clk(ref_clk), .clr(clr), .pin(op), .hiCnt(hiCnt), .loCnt(loCnt));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, e);
    checks++;
    if (g !== e) begin
      numErrors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d checks %0d", numErrors, checks);
    if (numErrors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // on-cycles over a window; windows span whole periods
  task automatic meas(input int k, input logic [15:0] h, l);
    clr = 1;
    cyc(1);
    clr = 0;
    cyc(k);
    chk(16'(hiCnt), h);
    chk(16'(loCnt), l);
  endtask
  task automatic sync_pb;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (pb !== 1'b1 && n < 99);
    if (pb !== 1'b1) begin
      numErrors++;
      $display("MISMATCH t=%0t no period boundary", $time);
      stop_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // redundant and push-pull on-time over whole periods
  task automatic run_modes;
    meas(16, 16'h0008, 16'h0008);
    oc.outputMode = pwmdou_pkg::MODE_PUSH_PULL;
    cyc(8);
    meas(16, 16'h0004, 16'h0004);
    oc.outputMode = pwmdou_pkg::MODE_REDUNDANT;
  endtask
  // master and own duty source, both taken at once
  task automatic run_source;
    gc.masterDutySelect = 1;
    cyc(1);
    chk(ad, 16'h0001);
    gc.masterDutySelect = 0;
    gd = 16'h0003;
    cyc(1);
    chk(ad, 16'h0003);
  endtask
  // deferred zero duty: old duty to the boundary, then no pulse at all
  task automatic run_deferred_zero;
    gc.immediateUpdate = 0;
    sync_pb();
    cyc(1);
    gd = 16'h0000;
    sync_pb();
    chk(ad, 16'h0003);
    meas(16, 16'h0000, 16'h0000);
    chk(ad, 16'h0000);
  endtask
  // cpu-clock override on, pattern change, then off
  task automatic run_override;
    oc.overridePatternBits = pwmdou_pkg::OVR_FULL_DUTY;
    oc.overrideEnable = 1;
    cyc(1);
    chk(16'(op), 16'h0002);
    meas(8, 16'h0008, 16'h0000);
    oc.overridePatternBits = pwmdou_pkg::OVR_ZERO_DUTY;
    cyc(1);
    chk(16'(op), 16'h0001);
    gc.immediateUpdate = 1;
    gd = 16'h0002;
    oc.overrideEnable = 0;
    cyc(4);
    meas(16, 16'h0008, 16'h0008);
  endtask
  // period-synchronised override waits for the boundary
  task automatic run_sync_override;
    sync_pb();
    cyc(1);
    oc.overrideSyncSelect = 1;
    oc.overridePatternBits = pwmdou_pkg::OVR_FULL_DUTY;
    oc.overrideEnable = 1;
    cyc(1);
    chk(16'(op), 16'h0003);
    sync_pb();
    chk(16'(op), 16'h0000);
    cyc(1);
    chk(16'(op), 16'h0002);
    oc.overrideSyncSelect = 0;
    oc.overrideEnable = 0;
    cyc(1);
    chk(16'(op), 16'h0003);
  endtask
  // mode code 0: the pair runs complementary
  task automatic run_complementary;
    oc.outputMode = 2'h0;
    cyc(4);
    meas(16, 16'h0008, 16'h0008);
    chk(16'(op.highSideOutput ^ op.lowSideOutput), 16'h0001);
    oc.outputMode = pwmdou_pkg::MODE_REDUNDANT;
  endtask
  // period length per prescale step, measured on the third boundary
  task automatic run_prescale;
    for (int i = 2; i < 5; i++) begin
      ps = 3'(i % 3);
      sync_pb();
      sync_pb();
      sync_pb();
      chk(16'(n), 16'(4 << (i % 3)));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(12);
    rst = 0;
    cyc(3);
    en = 1;
    cyc(8);
    run_modes();
    run_source();
    run_deferred_zero();
    run_override();
    run_sync_override();
    run_complementary();
    run_prescale();
    stop_test();
  end
endmodule
bind pwmdou_generator pwmdou_sva sva (
  .ref_clk            (ref_clk),
  .rst                (rst),
  .moduleEnable       (moduleEnable),
  .pwmClockPrescale   (pwmClockPrescale),
  .periodValue        (periodValue),
  .genCtrl            (genCtrl),
  .outCtrl            (outCtrl),
  .generatorDutyValue (generatorDutyValue),
  .masterDutyValue    (masterDutyValue),
  .activeDuty         (activeDuty),
  .periodBoundary     (periodBoundary),
  .outputPair         (outputPair)
);
